// *** logic/odmr_pkg.sv ***
// Package for the diagnostic monitoring register page: map, defaults, types
package odmr_pkg;

    // Byte addresses within the page
    localparam logic [7:0] ADDR_THR_LAST = 8'h29;
    localparam logic [7:0] ADDR_RSV_FIRST = 8'h2A;
    localparam logic [7:0] ADDR_FILL_FIRST = 8'h38;
    localparam logic [7:0] ADDR_FILL_LAST = 8'h5E;
    localparam logic [7:0] ADDR_CHECKSUM = 8'h5F;
    localparam logic [7:0] ADDR_TEMP = 8'h60;
    localparam logic [7:0] ADDR_SUPPLY = 8'h62;
    localparam logic [7:0] ADDR_DRIVE = 8'h64;
    localparam logic [7:0] ADDR_LAUNCH = 8'h66;
    localparam logic [7:0] ADDR_RXPWR = 8'h68;
    localparam logic [7:0] ADDR_HEADROOM = 8'h6A;
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h6E;
    localparam logic [7:0] ADDR_ALARM_FLAGS_A = 8'h70;
    localparam logic [7:0] ADDR_ALARM_FLAGS_B = 8'h71;
    localparam logic [7:0] ADDR_WARNING_FLAGS_A = 8'h74;
    localparam logic [7:0] ADDR_WARNING_FLAGS_B = 8'h75;

    // Threshold table layout: base of each quantity, then offset of each limit
    localparam int THR_TEMP = 0;
    localparam int THR_SUPPLY = 8;
    localparam int THR_DRIVE = 16;
    localparam int THR_LAUNCH = 24;
    localparam int THR_RXPWR = 32;
    localparam int THR_HEAD_ALARM = 40;
    localparam int THR_HEAD_WARN = 41;
    localparam int THR_HI_ALARM = 0;
    localparam int THR_LO_ALARM = 2;
    localparam int THR_HI_WARN = 4;
    localparam int THR_LO_WARN = 6;
    localparam int THR_BYTES = 42;
    localparam int FILL_BYTES = 39;

    // Factory limits, bytes 0 to 41, most significant byte first
    localparam logic [7:0] THR_DEFAULT [0:41] = '{
        8'h73, 8'h00, 8'hD8, 8'h00, 8'h69, 8'h00, 8'hE7, 8'h00,
        8'h98, 8'h58, 8'h69, 8'h78, 8'h8D, 8'hCC, 8'h74, 8'h04,
        8'h75, 8'h30, 8'h03, 8'hE8, 8'h75, 8'h30, 8'h03, 8'hE8,
        8'h1B, 8'h58, 8'h01, 8'hF4, 8'h17, 8'h70, 8'h03, 8'hE8,
        8'hFF, 8'hDC, 8'h00, 8'h00, 8'hFF, 8'hDC, 8'h00, 8'h00,
        8'h08, 8'h12};

    // Status/control bit positions
    localparam int SC_PIN_DISABLE = 7;
    localparam int SC_SOFT_DISABLE = 6;
    localparam int SC_FIXED_ONE = 4;
    localparam int SC_SPARE = 3;
    localparam int SC_SIGNAL_PRESENT = 1;
    localparam int SC_NOT_READY = 0;

    // Response limits of the page (pins to status, soft bits to effect, readiness)
    localparam int CLK_HZ = 125000000;
    localparam int SOFT_RESP_MS = 100;
    localparam int READY_MS = 1000;
    localparam longint SOFT_RESP_CYCLES = longint'(CLK_HZ) / 1000 * SOFT_RESP_MS;
    localparam longint READY_CYCLES = longint'(CLK_HZ) / 1000 * READY_MS;

    // One set of live measurements
    typedef struct packed {
        logic signed [15:0] temp;
        logic [15:0] supply;
        logic [15:0] drive;
        logic [15:0] launch;
        logic [15:0] rxpwr;
        logic signed [7:0] headroom;
    } odmr_meas_t;

    // The four flag bytes
    typedef struct packed {
        logic [7:0] alarm_a;
        logic [7:0] alarm_b;
        logic [7:0] warn_a;
        logic [7:0] warn_b;
    } odmr_flags_t;

    // Whole module state
    typedef struct packed {
        logic [2:0] dis_sync;
        logic dis_level;
        logic [2:0] sd_sync;
        logic sd_level;
        logic soft_dis;
        logic spare;
        logic not_ready;
        odmr_meas_t meas;
        odmr_flags_t flags;
        logic tx_off;
        logic ack;
        logic [7:0] rdata;
    } odmr_state_t;

    // 16-bit limit from the table
    function automatic logic [15:0] thr16(input int idx);
        return {THR_DEFAULT[idx], THR_DEFAULT[idx + 1]};
    endfunction

    // Low byte of the sum of bytes 0..94 as shipped
    function automatic logic [7:0] page_checksum(input logic [7:0] fill);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < THR_BYTES; i++) begin
            sum = sum + THR_DEFAULT[i];
        end
        for (int i = 0; i < FILL_BYTES; i++) begin
            sum = sum + fill;
        end
        return sum;
    endfunction

endpackage

// *** logic/odmr_regs.sv ***
// Diagnostic monitoring register page with live values, flags and soft control
//
// Contract
// - Temperature is 16-bit signed, 1/256 degree per count.
// - Supply voltage is 16-bit unsigned, 100 microvolts per count.
// - Drive current is 16-bit unsigned, 2 microamperes per count.
// - Launch power is 16-bit unsigned, 0.1 microwatt per count, informational.
// - Receive power is 16-bit unsigned, 0.1 microwatt per count.
// - Modulation headroom is 8-bit signed, 0.2 dB per count.
// - Reserved bytes read 00; writes acknowledged and dropped.
// - Byte 95 holds checksum of bytes 0 to 94.
// - Bytes 56 to 94 hold default contents, unused.
// - Status bit 7 shows live transmit-disable pin level.
// - Status bit 6 is software disable, ORed with pin to switch transmitter off.
// - Status bit 5 and receive flag bits 4..0 read 0, not stored.
// - Status bit 4 always reads 1, writes dropped.
// - Status bit 3 stores and returns writes, no other effect.
// - Status bit 2 always reads 0, writes dropped.
// - Status bit 1 mirrors signal-detect pin, 1 while the pin is high.
// - Status bit 0 reads 0 once measurements valid, within 1000 ms.
// - Soft bits act and pins reflect within 100 ms.
// - Byte 112 bits 7..0: temp, supply, drive, launch high/low alarms.
// - Byte 113 bits 7,6,5: receive high, receive low, headroom low alarms.
// - Byte 116 bits 7..4: temp and supply high/low warnings.
// - Byte 117 bits 7,6,5: receive high, receive low, headroom low warnings.
// - Live values from byte 96, MSB first, headroom at byte 106.
// - Limits in bytes 0..39 as MSB-first pairs; headroom limits 40, 41.
`timescale 1ns/1ps
`default_nettype none

module odmr_regs
    import odmr_pkg::*;
#(
    parameter logic [7:0] UNUSED_FILL = 8'h00
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic ack_o,
    output logic [7:0] rdata_o,
    input wire logic tx_disable_pin_i,
    input wire logic signal_detect_pin_i,
    input wire logic meas_valid_i,
    input wire odmr_meas_t meas_i,
    output logic tx_off_o
);

    localparam logic [7:0] CHECKSUM = page_checksum(UNUSED_FILL);

    odmr_state_t st_r;
    odmr_state_t st_nxt;

    // Compare one measurement set against every limit except the drive and launch warning limits
    function automatic odmr_flags_t calc_flags(input odmr_meas_t m);
        odmr_flags_t f;
        f = '0;
        f.alarm_a[7] = m.temp > $signed(thr16(THR_TEMP + THR_HI_ALARM));
        f.alarm_a[6] = m.temp < $signed(thr16(THR_TEMP + THR_LO_ALARM));
        f.alarm_a[5] = m.supply > thr16(THR_SUPPLY + THR_HI_ALARM);
        f.alarm_a[4] = m.supply < thr16(THR_SUPPLY + THR_LO_ALARM);
        f.alarm_a[3] = m.drive > thr16(THR_DRIVE + THR_HI_ALARM);
        f.alarm_a[2] = m.drive < thr16(THR_DRIVE + THR_LO_ALARM);
        f.alarm_a[1] = m.launch > thr16(THR_LAUNCH + THR_HI_ALARM);
        f.alarm_a[0] = m.launch < thr16(THR_LAUNCH + THR_LO_ALARM);
        f.alarm_b[7] = m.rxpwr > thr16(THR_RXPWR + THR_HI_ALARM);
        f.alarm_b[6] = m.rxpwr < thr16(THR_RXPWR + THR_LO_ALARM);
        f.alarm_b[5] = m.headroom < $signed(THR_DEFAULT[THR_HEAD_ALARM]);
        f.warn_a[7] = m.temp > $signed(thr16(THR_TEMP + THR_HI_WARN));
        f.warn_a[6] = m.temp < $signed(thr16(THR_TEMP + THR_LO_WARN));
        f.warn_a[5] = m.supply > thr16(THR_SUPPLY + THR_HI_WARN);
        f.warn_a[4] = m.supply < thr16(THR_SUPPLY + THR_LO_WARN);
        f.warn_b[7] = m.rxpwr > thr16(THR_RXPWR + THR_HI_WARN);
        f.warn_b[6] = m.rxpwr < thr16(THR_RXPWR + THR_LO_WARN);
        f.warn_b[5] = m.headroom < $signed(THR_DEFAULT[THR_HEAD_WARN]);
        return f;
    endfunction

    // Read decode of the page; anything not listed reads zero
    function automatic logic [7:0] read_byte(input odmr_state_t s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a <= ADDR_THR_LAST) begin
            d = THR_DEFAULT[a[5:0]];
        end else if (a >= ADDR_FILL_FIRST && a <= ADDR_FILL_LAST) begin
            d = UNUSED_FILL;
        end else begin
            case (a)
                ADDR_CHECKSUM: d = CHECKSUM;
                ADDR_TEMP: d = s.meas.temp[15:8];
                ADDR_TEMP + 8'h01: d = s.meas.temp[7:0];
                ADDR_SUPPLY: d = s.meas.supply[15:8];
                ADDR_SUPPLY + 8'h01: d = s.meas.supply[7:0];
                ADDR_DRIVE: d = s.meas.drive[15:8];
                ADDR_DRIVE + 8'h01: d = s.meas.drive[7:0];
                ADDR_LAUNCH: d = s.meas.launch[15:8];
                ADDR_LAUNCH + 8'h01: d = s.meas.launch[7:0];
                ADDR_RXPWR: d = s.meas.rxpwr[15:8];
                ADDR_RXPWR + 8'h01: d = s.meas.rxpwr[7:0];
                ADDR_HEADROOM: d = s.meas.headroom;
                ADDR_STATUS_CONTROL: begin
                    d[SC_PIN_DISABLE] = s.dis_level;
                    d[SC_SOFT_DISABLE] = s.soft_dis;
                    d[SC_FIXED_ONE] = 1'b1;
                    d[SC_SPARE] = s.spare;
                    d[SC_SIGNAL_PRESENT] = s.sd_level;
                    d[SC_NOT_READY] = s.not_ready;
                end
                ADDR_ALARM_FLAGS_A: d = s.flags.alarm_a;
                ADDR_ALARM_FLAGS_B: d = s.flags.alarm_b;
                ADDR_WARNING_FLAGS_A: d = s.flags.warn_a;
                ADDR_WARNING_FLAGS_B: d = s.flags.warn_b;
                default: d = 8'h00;
            endcase
        end
        return d;
    endfunction

    // Next state: pin filters, soft bits, measurement capture and bus answer
    always_comb begin
        st_nxt = st_r;
        // Three stages per pin; the level moves only when stages two and three agree
        st_nxt.dis_sync = {st_r.dis_sync[1:0], tx_disable_pin_i};
        st_nxt.sd_sync = {st_r.sd_sync[1:0], signal_detect_pin_i};
        if (st_r.dis_sync[1] == st_r.dis_sync[2]) begin
            st_nxt.dis_level = st_r.dis_sync[2];
        end
        if (st_r.sd_sync[1] == st_r.sd_sync[2]) begin
            st_nxt.sd_level = st_r.sd_sync[2];
        end
        // Only bits 6 and 3 of the status byte hold writes; all else is dropped
        if (req_i && we_i && addr_i == ADDR_STATUS_CONTROL) begin
            st_nxt.soft_dis = wdata_i[SC_SOFT_DISABLE];
            st_nxt.spare = wdata_i[SC_SPARE];
        end
        // A fresh set replaces the live values and all flags at once
        if (meas_valid_i) begin
            st_nxt.meas = meas_i;
            st_nxt.flags = calc_flags(meas_i);
            st_nxt.not_ready = 1'b0;
        end
        // Transmitter off from either source, visible one cycle after a soft write, four cycles after a pin change
        st_nxt.tx_off = st_nxt.dis_level | st_nxt.soft_dis;
        // Every request is answered the next cycle, writes included
        st_nxt.ack = req_i;
        st_nxt.rdata = (req_i && !we_i) ? read_byte(st_r, addr_i) : 8'h00;
    end

    // State register; data is not ready until the first measurement arrives
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
            st_r.not_ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ack_o = st_r.ack;
    assign rdata_o = st_r.rdata;
    assign tx_off_o = st_r.tx_off;

    // Checks on the design's own behaviour
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_soft_set;
        req_i && we_i && addr_i == ADDR_STATUS_CONTROL && wdata_i[SC_SOFT_DISABLE];
    endsequence

    sequence s_status_read;
        req_i && !we_i && addr_i == ADDR_STATUS_CONTROL;
    endsequence

    property p_soft_disable;
        s_soft_set |=> tx_off_o;
    endproperty
    a_soft_disable: assert property (p_soft_disable) else $error("soft disable did not turn transmitter off");

    property p_pin_disable;
        tx_disable_pin_i [*5] |=> tx_off_o;
    endproperty
    a_pin_disable: assert property (p_pin_disable) else $error("disable pin did not turn transmitter off");

    property p_pin_status;
        tx_disable_pin_i [*5] ##0 s_status_read |=> rdata_o[SC_PIN_DISABLE];
    endproperty
    a_pin_status: assert property (p_pin_status) else $error("status bit 7 does not follow pin");

    property p_sd_status;
        !signal_detect_pin_i [*5] ##0 s_status_read |=> !rdata_o[SC_SIGNAL_PRESENT];
    endproperty
    a_sd_status: assert property (p_sd_status) else $error("status bit 1 does not follow signal detect");

    property p_fixed_bits;
        s_status_read |=> rdata_o[SC_FIXED_ONE] && !rdata_o[5] && !rdata_o[2];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong");

    property p_spare_store;
        req_i && we_i && addr_i == ADDR_STATUS_CONTROL ##1 s_status_read
            |=> rdata_o[SC_SPARE] == $past(wdata_i[SC_SPARE], 2);
    endproperty
    a_spare_store: assert property (p_spare_store) else $error("bit 3 did not hold written value");

    property p_reserved_zero;
        req_i && !we_i && (addr_i == 8'h6B || addr_i == 8'h6F || addr_i == 8'h72 || addr_i == 8'h76)
            |=> ack_o && rdata_o == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero");

    property p_ack;
        req_i |=> ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered next cycle");

    property p_ready;
        meas_valid_i ##1 s_status_read |=> !rdata_o[SC_NOT_READY];
    endproperty
    a_ready: assert property (p_ready) else $error("data ready bit not cleared");

    property p_temp_high;
        meas_valid_i && meas_i.temp > $signed(thr16(THR_TEMP + THR_HI_ALARM))
            |=> st_r.flags.alarm_a[7] && st_r.meas.temp == $past(meas_i.temp);
    endproperty
    a_temp_high: assert property (p_temp_high) else $error("temperature high alarm missed");

    property p_rx_low_flag;
        meas_valid_i |=> st_r.flags.warn_b[4:0] == 5'h00 && st_r.flags.alarm_b[4:0] == 5'h00
            && st_r.flags.alarm_b[6] == ($past(meas_i.rxpwr) < thr16(THR_RXPWR + THR_LO_ALARM));
    endproperty
    a_rx_low_flag: assert property (p_rx_low_flag) else $error("receive flag byte wrong");

    property p_checksum;
        req_i && !we_i && addr_i == ADDR_CHECKSUM |=> rdata_o == CHECKSUM;
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum byte wrong");

    // Bus-side steps shared by the checks below
    sequence s_status_write;
        req_i && we_i && addr_i == ADDR_STATUS_CONTROL;
    endsequence

    sequence s_read_any;
        req_i && !we_i;
    endsequence

    sequence s_fresh_read;
        meas_valid_i ##1 (req_i && !we_i);
    endsequence

    // Answer strobe and data only follow a request
    property p_ack_idle;
        !req_i |=> !ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("answer without request");

    property p_rdata_idle;
        !(req_i && !we_i) |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

    property p_write_answer;
        req_i && we_i |=> ack_o && rdata_o == 8'h00;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered cleanly");

    property p_reserved_range;
        s_read_any ##0 (addr_i >= ADDR_RSV_FIRST && addr_i < ADDR_FILL_FIRST) |=> rdata_o == 8'h00;
    endproperty
    a_reserved_range: assert property (p_reserved_range) else $error("reserved range not zero");

    property p_thr_table;
        s_read_any ##0 (addr_i <= ADDR_THR_LAST) |=> rdata_o == THR_DEFAULT[$past(addr_i[5:0])];
    endproperty
    a_thr_table: assert property (p_thr_table) else $error("limit byte wrong");

    property p_fill;
        s_read_any ##0 (addr_i >= ADDR_FILL_FIRST && addr_i <= ADDR_FILL_LAST) |=> rdata_o == UNUSED_FILL;
    endproperty
    a_fill: assert property (p_fill) else $error("unused byte wrong");

    // Status byte: writes never reach the fixed bits
    property p_fixed_after_write;
        s_status_write ##1 s_status_read |=> rdata_o[SC_FIXED_ONE] && !rdata_o[5] && !rdata_o[2];
    endproperty
    a_fixed_after_write: assert property (p_fixed_after_write) else $error("fixed bit took a write");

    property p_soft_readback;
        s_status_write ##1 s_status_read |=> rdata_o[SC_SOFT_DISABLE] == $past(wdata_i[SC_SOFT_DISABLE], 2);
    endproperty
    a_soft_readback: assert property (p_soft_readback) else $error("bit 6 did not hold written value");

    property p_soft_clear;
        s_status_write ##0 (!wdata_i[SC_SOFT_DISABLE] && st_r.dis_sync[2:1] == 2'b00) |=> !tx_off_o;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("transmitter stayed off");

    property p_pin_off;
        !tx_disable_pin_i [*5] ##0 (!st_r.soft_dis && !(req_i && we_i && addr_i == ADDR_STATUS_CONTROL))
            |=> !tx_off_o;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("transmitter off with no cause");

    property p_pin_release;
        !tx_disable_pin_i [*5] ##0 s_status_read |=> !rdata_o[SC_PIN_DISABLE];
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("status bit 7 stuck high");

    property p_sd_high;
        signal_detect_pin_i [*5] ##0 s_status_read |=> rdata_o[SC_SIGNAL_PRESENT];
    endproperty
    a_sd_high: assert property (p_sd_high) else $error("status bit 1 stuck low");

    property p_ready_sticky;
        !st_r.not_ready |=> !st_r.not_ready;
    endproperty
    a_ready_sticky: assert property (p_ready_sticky) else $error("data ready lost");

    // A fresh set must be readable, one byte of each live value, in the cycle after it arrives
    property p_temp_msb;
        s_fresh_read ##0 (addr_i == ADDR_TEMP) |=> rdata_o == $past(meas_i.temp[15:8], 2);
    endproperty
    a_temp_msb: assert property (p_temp_msb) else $error("temperature byte wrong");

    property p_supply_lsb;
        s_fresh_read ##0 (addr_i == ADDR_SUPPLY + 8'h01) |=> rdata_o == $past(meas_i.supply[7:0], 2);
    endproperty
    a_supply_lsb: assert property (p_supply_lsb) else $error("supply byte wrong");

    property p_drive_msb;
        s_fresh_read ##0 (addr_i == ADDR_DRIVE) |=> rdata_o == $past(meas_i.drive[15:8], 2);
    endproperty
    a_drive_msb: assert property (p_drive_msb) else $error("drive byte wrong");

    property p_launch_lsb;
        s_fresh_read ##0 (addr_i == ADDR_LAUNCH + 8'h01) |=> rdata_o == $past(meas_i.launch[7:0], 2);
    endproperty
    a_launch_lsb: assert property (p_launch_lsb) else $error("launch byte wrong");

    property p_rxpwr_msb;
        s_fresh_read ##0 (addr_i == ADDR_RXPWR) |=> rdata_o == $past(meas_i.rxpwr[15:8], 2);
    endproperty
    a_rxpwr_msb: assert property (p_rxpwr_msb) else $error("receive power byte wrong");

    property p_headroom_byte;
        s_fresh_read ##0 (addr_i == ADDR_HEADROOM) |=> rdata_o == $past(meas_i.headroom, 2);
    endproperty
    a_headroom_byte: assert property (p_headroom_byte) else $error("headroom byte wrong");

    // Flags move only with a new set, and then follow the limits
    property p_flags_hold;
        !meas_valid_i |=> $stable(st_r.flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed without update");

    property p_supply_high;
        meas_valid_i |=> st_r.flags.alarm_a[5] == ($past(meas_i.supply) > thr16(THR_SUPPLY + THR_HI_ALARM));
    endproperty
    a_supply_high: assert property (p_supply_high) else $error("supply high alarm wrong");

    property p_launch_low;
        meas_valid_i |=> st_r.flags.alarm_a[0] == ($past(meas_i.launch) < thr16(THR_LAUNCH + THR_LO_ALARM));
    endproperty
    a_launch_low: assert property (p_launch_low) else $error("launch low alarm wrong");

    property p_head_alarm;
        meas_valid_i |=> st_r.flags.alarm_b[5] == ($past(meas_i.headroom) < $signed(THR_DEFAULT[THR_HEAD_ALARM]));
    endproperty
    a_head_alarm: assert property (p_head_alarm) else $error("headroom alarm wrong");

    property p_temp_low_warn;
        meas_valid_i |=> st_r.flags.warn_a[6] == ($past(meas_i.temp) < $signed(thr16(THR_TEMP + THR_LO_WARN)));
    endproperty
    a_temp_low_warn: assert property (p_temp_low_warn) else $error("temperature low warning wrong");

    property p_rx_high_warn;
        meas_valid_i |=> st_r.flags.warn_b[7] == ($past(meas_i.rxpwr) > thr16(THR_RXPWR + THR_HI_WARN));
    endproperty
    a_rx_high_warn: assert property (p_rx_high_warn) else $error("receive high warning wrong");

endmodule

`default_nettype wire

// *** sim/odmr_host_model.sv ***
// Host management controller model issuing byte accesses to the page
`timescale 1ns/1ps
`default_nettype none

module odmr_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [7:0] rdata_i,
    output logic req_o,
    output logic we_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    // Idle bus: no request, qualifiers carry a pattern rather than a stale access
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        addr_o = 8'hA5;
        wdata_o = 8'h5A;
    end

    // One access: a single-cycle request, the answer expected exactly one edge later
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic ok);
        @(negedge clk_i);
        req_o <= 1'b1;
        we_o <= w;
        addr_o <= a;
        wdata_o <= d;
        @(negedge clk_i);
        // The answer stands for one cycle only, so it is taken mid-cycle before release
        ok = (ack_i === 1'b1);
        q = rdata_i;
        req_o <= 1'b0;
        // Inverted after release so late sampling of qualifiers shows up
        we_o <= ~w;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
endmodule

`default_nettype wire

// *** sim/optical_diag_monitor_regs_tb_top.sv ***
// Self-checking bench for the diagnostic monitoring register page
`timescale 1ns/1ps
`default_nettype none

module optical_diag_monitor_regs_tb_top
    import odmr_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [7:0] e;} odmr_row_t;
    typedef struct packed {odmr_meas_t m; odmr_flags_t f;} odmr_set_t;
    localparam logic [7:0] FILL = 8'h5A;

    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic meas_valid_i = 1'b0;
    logic tx_disable_pin_i = 1'b0;
    logic signal_detect_pin_i = 1'b0;
    odmr_meas_t meas_i = '0;
    logic req, we, ack, tx_off;
    logic [7:0] addr, wdata, rdata;
    int err_total = 0;
    int n_compared = 0;

    // Fixed bytes: limits, reserved places, unused fill, unmapped upper half
    odmr_row_t rows [14] = '{'{8'h00, 8'h73}, '{8'h01, 8'h00}, '{8'h28, 8'h08}, '{8'h29, 8'h12},
        '{8'h2A, 8'h00}, '{8'h37, 8'h00}, '{8'h38, FILL}, '{8'h5E, FILL}, '{8'h6B, 8'h00},
        '{8'h6F, 8'h00}, '{8'h72, 8'h00}, '{8'h77, 8'h00}, '{8'h80, 8'h00}, '{8'hFF, 8'h00}};
    // Measurement sets with the flag bytes they must raise; signed cases in the second
    odmr_set_t sets [3] = '{
        '{'{16'h7400, 16'h6000, 16'h8000, 16'h0100, 16'hFFFF, 8'h05}, '{8'h99, 8'hA0, 8'h90, 8'hA0}},
        '{'{16'hD000, 16'hA000, 16'h0100, 16'h2000, 16'h0000, 8'hF0}, '{8'h66, 8'h20, 8'h60, 8'h20}},
        '{'{16'h1900, 16'h8000, 16'h1000, 16'h1000, 16'h1000, 8'h20}, '{8'h00, 8'h00, 8'h00, 8'h00}}};

    always #4 ref_clk_i = ~ref_clk_i;

    odmr_regs #(.UNUSED_FILL(FILL)) dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req),
        .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata),
        .tx_disable_pin_i(tx_disable_pin_i), .signal_detect_pin_i(signal_detect_pin_i),
        .meas_valid_i(meas_valid_i), .meas_i(meas_i), .tx_off_o(tx_off));

    odmr_host_model host (.clk_i(ref_clk_i), .ack_i(ack), .rdata_i(rdata), .req_o(req), .we_o(we),
        .addr_o(addr), .wdata_o(wdata));

    task automatic final_report();
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A missing answer is counted and ends the run, since later reads would be meaningless
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic ok;
        host.acc(w, a, d, q, ok);
        if (ok !== 1'b1) begin
            err_total++;
            final_report();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask

    // Measurement strobe for one cycle; data inverted afterwards to catch late capture
    task automatic put(input odmr_meas_t m);
        @(negedge ref_clk_i);
        meas_i <= m;
        meas_valid_i <= 1'b1;
        @(negedge ref_clk_i);
        meas_valid_i <= 1'b0;
        meas_i <= ~m;
    endtask

    task automatic pins(input logic dis, input logic sd);
        @(negedge ref_clk_i);
        tx_disable_pin_i <= dis;
        signal_detect_pin_i <= sd;
        repeat (6) @(negedge ref_clk_i);
    endtask

    // Main sequence
    initial begin
        logic [7:0] s;
        repeat (5) @(negedge ref_clk_i);
        resetn_i <= 1'b1;
        chk({7'h00, tx_off}, 8'h00);
        rd(ADDR_STATUS_CONTROL, 8'h11);
        wr(ADDR_STATUS_CONTROL, 8'hFF);
        chk({7'h00, tx_off}, 8'h01);
        rd(ADDR_STATUS_CONTROL, 8'h59);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        chk({7'h00, tx_off}, 8'h00);
        pins(1'b1, 1'b1);
        chk({7'h00, tx_off}, 8'h01);
        rd(ADDR_STATUS_CONTROL, 8'h93);
        wr(ADDR_STATUS_CONTROL, 8'h40);
        pins(1'b0, 1'b0);
        chk({7'h00, tx_off}, 8'h01);
        rd(ADDR_STATUS_CONTROL, 8'h51);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        chk({7'h00, tx_off}, 8'h00);
        // Fixed bytes ignore writes of their inverse
        for (int i = 0; i < 14; i++) begin
            wr(rows[i].a, ~rows[i].e);
            rd(rows[i].a, rows[i].e);
        end
        s = 8'h00;
        for (int i = 0; i < THR_BYTES; i++) s = s + THR_DEFAULT[i];
        for (int i = 0; i < FILL_BYTES; i++) s = s + FILL;
        rd(ADDR_CHECKSUM, s);
        // Each set: live bytes most significant first, then the four flag bytes
        for (int k = 0; k < 3; k++) begin
            put(sets[k].m);
            for (int j = 0; j < 11; j++) begin
                rd(8'(ADDR_TEMP + j), sets[k].m[87 - 8 * j -: 8]);
            end
            rd(ADDR_ALARM_FLAGS_A, sets[k].f.alarm_a);
            rd(ADDR_ALARM_FLAGS_B, sets[k].f.alarm_b);
            rd(ADDR_WARNING_FLAGS_A, sets[k].f.warn_a);
            rd(ADDR_WARNING_FLAGS_B, sets[k].f.warn_b);
            rd(ADDR_STATUS_CONTROL, 8'h10);
        end
        // Second reset in mid-run clears live values and readiness
        @(negedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (5) @(negedge ref_clk_i);
        resetn_i <= 1'b1;
        chk(rdata, 8'h00);
        rd(ADDR_STATUS_CONTROL, 8'h11);
        rd(ADDR_TEMP, 8'h00);
        final_report();
    end
endmodule

`default_nettype wire
